// *** logic/rahp_pkg.sv ***
// rahp_pkg: offsets, field layouts, reset values and carrier types for the
// receive address ram and dma head pointer register block.
// assumes a 32-bit byte-addressed plain register port.
package rahp_pkg;

  // ==========================================================================
  // register map (byte offsets, one aligned word each; each hdp base starts eight words)
  localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
  localparam logic [7:0] INDEX_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] LOOKUP_OFS = 8'h10;
  localparam logic [7:0] TX_HDP_BASE = 8'h40;
  localparam logic [7:0] RX_HDP_BASE = 8'h60;

  // ==========================================================================
  // field positions of the low word, index width and table sizes
  localparam int VALID_BIT = 20;
  localparam int MATCH_BIT = 19;
  localparam int CHAN_LSB = 16;
  localparam int CHAN_W = 3;
  localparam int BYTE0_LSB = 8;
  localparam int BYTE1_LSB = 0;
  localparam int INDEX_W = 5;
  localparam int ENTRIES = 32;
  localparam int CHANNELS = 8;

  // ==========================================================================
  // reset values
  localparam logic [31:0] HIGH_RST = 32'h0000_0000;
  localparam logic [31:0] HDP_RST = 32'h0000_0000;
  localparam logic [4:0] INDEX_RST = 5'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic match;
    logic [2:0] chan;
    logic [47:0] mac;
  } rahp_entry_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rahp_bus_type;

  typedef struct packed {
    logic hit;
    logic reject;
    logic [2:0] chan;
  } rahp_result_type;

endpackage : rahp_pkg

// *** logic/rahp_addr_ram.sv ***
// rahp_addr_ram: 32-entry receive address ram with a combinational lookup.
// assumes the write port is pulsed once per commit on the system clock.
`timescale 1ns/1ns
module rahp_addr_ram
  import rahp_pkg::*;
#(
  parameter int DEPTH = ENTRIES
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // write port
  input wire logic i_we,
  input wire logic [INDEX_W-1:0] i_widx,
  input wire rahp_entry_type i_wentry,
  // lookup port
  input wire logic [47:0] i_dest,
  output rahp_result_type o_result
);

  rahp_entry_type mem_q [DEPTH];
  logic [DEPTH-1:0] hit_vec;
  logic [DEPTH-1:0] rej_vec;
  logic [CHAN_W-1:0] hit_chan;

  // ==========================================================================
  // storage; cleared at reset so stale entries never match
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < DEPTH; k++)
    begin
      if (i_rst)
        mem_q[k] <= '0;
      else if (i_ce && i_we && (int'(i_widx) == k))
        mem_q[k] <= i_wentry;
    end
  end

  // ==========================================================================
  // compare; lowest matching index picks the channel
  always_comb
  begin
    hit_chan = '0;
    for (int k = DEPTH - 1; k >= 0; k--)
    begin
      hit_vec[k] = mem_q[k].valid && mem_q[k].match && (mem_q[k].mac == i_dest);
      rej_vec[k] = mem_q[k].valid && !mem_q[k].match && (mem_q[k].mac == i_dest);
      if (hit_vec[k])
        hit_chan = mem_q[k].chan;
    end
  end

  // filter wins over match; channel ignored for filter entries
  assign o_result.reject = |rej_vec;
  assign o_result.hit = (|hit_vec) && !(|rej_vec);
  assign o_result.chan = o_result.hit ? hit_chan : '0;

endmodule : rahp_addr_ram

// *** logic/rahp_hdp_bank.sv ***
// rahp_hdp_bank: per-channel head descriptor pointers for one direction.
// assumes the dma engine clears a pointer through the clear strobes.
`timescale 1ns/1ns
module rahp_hdp_bank
  import rahp_pkg::*;
#(
  parameter int NCH = CHANNELS
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // software write
  input wire logic [NCH-1:0] i_wr,
  input wire logic [31:0] i_wdata,
  // dma side
  input wire logic [NCH-1:0] i_clr,
  output logic [NCH-1:0] o_start,
  output logic [NCH-1:0] o_err,
  output logic [NCH*32-1:0] o_ptr
);

  logic [31:0] ptr_q [NCH];
  logic [NCH-1:0] start_q;
  logic [NCH-1:0] err_q;

  // ==========================================================================
  // a write always loads; loading over a live pointer is flagged only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < NCH; k++)
        ptr_q[k] <= HDP_RST;
      start_q <= '0;
      err_q <= '0;
    end
    else if (i_ce)
    begin
      for (int k = 0; k < NCH; k++)
      begin
        start_q[k] <= i_wr[k] && (i_wdata != 32'h0000_0000);
        err_q[k] <= i_wr[k] && (ptr_q[k] != 32'h0000_0000);
        if (i_wr[k])
          ptr_q[k] <= i_wdata;
        else if (i_clr[k])
          ptr_q[k] <= HDP_RST;
      end
    end
  end

  assign o_start = start_q;
  assign o_err = err_q;

  always_comb
  begin
    for (int k = 0; k < NCH; k++)
      o_ptr[k*32 +: 32] = ptr_q[k];
  end

endmodule : rahp_hdp_bank

// *** logic/rahp_top.sv ***
// rahp_top: register port for the receive address ram and head pointers.
// assumes a single-cycle master on the system clock; reads answer next cycle.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module rahp_top
  import rahp_pkg::*;
(
  // clock, reset, enable
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // receive lookup
  input wire logic [47:0] I_RX_DEST,
  output logic O_RX_HIT,
  output logic O_RX_REJECT,
  output logic [2:0] O_RX_CHAN,
  // dma engine
  input wire logic [7:0] I_TX_CLR,
  input wire logic [7:0] I_RX_CLR,
  output logic [7:0] O_TX_START,
  output logic [7:0] O_RX_START,
  output logic [255:0] O_TX_PTR,
  output logic [255:0] O_RX_PTR
);

  // ==========================================================================
  // byte packing helpers shared by write and read paths
  function automatic logic [47:0] mac_from_words(input logic [31:0] hi, input logic [15:0] lo);
    mac_from_words = {hi[7:0], hi[15:8], hi[23:16], hi[31:24], lo[7:0], lo[15:8]};
  endfunction : mac_from_words

  function automatic logic [31:0] low_from_entry(input rahp_entry_type e);
    low_from_entry = '0;
    low_from_entry[VALID_BIT] = e.valid;
    low_from_entry[MATCH_BIT] = e.match;
    low_from_entry[CHAN_LSB +: CHAN_W] = e.chan;
    low_from_entry[BYTE0_LSB +: 8] = e.mac[7:0];
    low_from_entry[BYTE1_LSB +: 8] = e.mac[15:8];
  endfunction : low_from_entry

  rahp_bus_type bus;
  rahp_entry_type new_entry;
  rahp_entry_type shadow_q [ENTRIES];
  rahp_result_type result;

  logic [31:0] high_q;
  logic [INDEX_W-1:0] index_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] err_q;
  logic [7:0] tx_err;
  logic [7:0] rx_err;
  logic [7:0] tx_wr;
  logic [7:0] rx_wr;

  // ==========================================================================
  // decode
  assign bus.wr = I_WR;
  assign bus.rd = I_RD;
  assign bus.addr = I_ADDR;
  assign bus.wdata = I_WDATA;

  wire sel_low = (bus.addr == ADDR_LOW_OFS);
  wire sel_high = (bus.addr == ADDR_HIGH_OFS);
  wire sel_index = (bus.addr == INDEX_OFS);
  wire sel_status = (bus.addr == STATUS_OFS);
  wire sel_lookup = (bus.addr == LOOKUP_OFS);
  wire sel_tx = (bus.addr[7:5] == TX_HDP_BASE[7:5]) && (bus.addr[1:0] == 2'h0);
  wire sel_rx = (bus.addr[7:5] == RX_HDP_BASE[7:5]) && (bus.addr[1:0] == 2'h0);
  wire [2:0] ch_sel = bus.addr[4:2];
  wire commit = I_CE && bus.wr && sel_low;

  assign tx_wr = (bus.wr && sel_tx && I_CE) ? (8'h01 << ch_sel) : 8'h00;
  assign rx_wr = (bus.wr && sel_rx && I_CE) ? (8'h01 << ch_sel) : 8'h00;

  // merged entry: staged high word plus the low write in flight
  assign new_entry.valid = bus.wdata[VALID_BIT];
  assign new_entry.match = bus.wdata[MATCH_BIT];
  assign new_entry.chan = bus.wdata[CHAN_LSB +: CHAN_W];
  assign new_entry.mac = mac_from_words(high_q, bus.wdata[15:0]);

  // ==========================================================================
  // staging, index and sticky error flags
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      high_q <= HIGH_RST;
      index_q <= INDEX_RST;
      err_q <= '0;
    end
    else if (I_CE)
    begin
      if (bus.wr && sel_high)
        high_q <= bus.wdata;
      if (bus.wr && sel_index)
        index_q <= bus.wdata[INDEX_W-1:0];
      // new error wins over a clear in the same cycle
      err_q <= ((bus.wr && sel_status) ? (err_q & ~bus.wdata[15:0]) : err_q)
               | {rx_err, tx_err};
    end
  end

  // readback copy; the lookup ram has only a compare port
  always_ff @(posedge I_SYS_CLK)
  begin
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (I_RST)
        shadow_q[k] <= '0;
      else if (commit && (int'(index_q) == k))
        shadow_q[k] <= new_entry;
    end
  end

  // ==========================================================================
  // read path; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sel_low)
      rdata_d = low_from_entry(shadow_q[index_q]);
    else if (sel_high)
      rdata_d = high_q;
    else if (sel_index)
      rdata_d = {27'h0000000, index_q};
    else if (sel_status)
      rdata_d = {16'h0000, err_q};
    else if (sel_lookup)
      rdata_d = {27'h0000000, result.hit, result.reject, result.chan};
    else if (sel_tx)
      rdata_d = O_TX_PTR[{ch_sel, 5'h00} +: 32];
    else if (sel_rx)
      rdata_d = O_RX_PTR[{ch_sel, 5'h00} +: 32];
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      rdata_q <= 32'h0000_0000;
    else if (I_CE)
      rdata_q <= bus.rd ? rdata_d : 32'h0000_0000;
  end

  assign O_RDATA = rdata_q;

  // ==========================================================================
  // submodules
  rahp_addr_ram #(
    .DEPTH(ENTRIES)
  ) u_ram (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_we(commit),
    .i_widx(index_q),
    .i_wentry(new_entry),
    .i_dest(I_RX_DEST),
    .o_result(result)
  );

  assign O_RX_HIT = result.hit;
  assign O_RX_REJECT = result.reject;
  assign O_RX_CHAN = result.chan;

  rahp_hdp_bank #(
    .NCH(CHANNELS)
  ) u_tx_hdp (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_wr(tx_wr),
    .i_wdata(bus.wdata),
    .i_clr(I_TX_CLR),
    .o_start(O_TX_START),
    .o_err(tx_err),
    .o_ptr(O_TX_PTR)
  );

  rahp_hdp_bank #(
    .NCH(CHANNELS)
  ) u_rx_hdp (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_wr(rx_wr),
    .i_wdata(bus.wdata),
    .i_clr(I_RX_CLR),
    .o_start(O_RX_START),
    .o_err(rx_err),
    .o_ptr(O_RX_PTR)
  );

endmodule : rahp_top

// *** test/rahp_sva.sv ***
// rahp_sva: port checks for the address ram and head pointer block.
// assumes one clock domain, bound to rahp_top.
`timescale 1ns/1ns
module rahp_sva
  import rahp_pkg::*;
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // register port
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  // lookup and dma
  input wire logic O_RX_HIT,
  input wire logic O_RX_REJECT,
  input wire logic [2:0] O_RX_CHAN,
  input wire logic [7:0] O_TX_START,
  input wire logic [7:0] O_RX_START,
  input wire logic [255:0] O_TX_PTR,
  input wire logic [255:0] O_RX_PTR
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // ====
  // sequences
  sequence s_wr(logic [7:0] a);
    I_CE && I_WR && I_ADDR == a && I_WDATA != 32'h0;
  endsequence
  sequence s_rd(logic [7:0] a);
    I_CE && I_RD && I_ADDR == a;
  endsequence
  // ====
  // properties
  property p_tx_go;
    s_wr(TX_HDP_BASE) |=> O_TX_START[0] && O_TX_PTR[31:0] == $past(I_WDATA);
  endproperty
  property p_rx_go;
    s_wr(RX_HDP_BASE + 8'h1C) |=> O_RX_START[7] && O_RX_PTR[255:224] == $past(I_WDATA);
  endproperty
  property p_no_go;
    I_CE && !I_WR |=> O_TX_START == 8'h00 && O_RX_START == 8'h00;
  endproperty
  property p_rd_idle;
    I_CE && !I_RD |=> O_RDATA == 32'h0;
  endproperty
  property p_idx_rd;
    s_rd(INDEX_OFS) |=> O_RDATA[31:5] == 27'h0;
  endproperty
  property p_low_rd;
    s_rd(ADDR_LOW_OFS) |=> O_RDATA[31:21] == 11'h0;
  endproperty
  property p_rej_wins;
    O_RX_REJECT |-> !O_RX_HIT;
  endproperty
  property p_chan_zero;
    !O_RX_HIT |-> O_RX_CHAN == 3'h0;
  endproperty
  property p_hi_stage;
    // a second staging write in the gap would legally replace the value
    s_wr(ADDR_HIGH_OFS) ##1 !(I_CE && I_WR && I_ADDR == ADDR_HIGH_OFS) ##1 s_rd(ADDR_HIGH_OFS)
      |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("tx start or pointer wrong");
  a_rx_go: assert property (p_rx_go) else $error("rx start or pointer wrong");
  a_no_go: assert property (p_no_go) else $error("start without write");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_idx_rd: assert property (p_idx_rd) else $error("index upper bits set");
  a_low_rd: assert property (p_low_rd) else $error("low word upper bits set");
  a_rej_wins: assert property (p_rej_wins) else $error("hit with reject");
  a_chan_zero: assert property (p_chan_zero) else $error("channel without hit");
  a_hi_stage: assert property (p_hi_stage) else $error("high word not staged");
endmodule : rahp_sva

bind rahp_top rahp_sva u_sva (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_RX_HIT(O_RX_HIT),
  .O_RX_REJECT(O_RX_REJECT), .O_RX_CHAN(O_RX_CHAN), .O_TX_START(O_TX_START),
  .O_RX_START(O_RX_START), .O_TX_PTR(O_TX_PTR), .O_RX_PTR(O_RX_PTR)
);

// *** test/rahp_tb_top.sv ***
// rahp_tb_top: directed register sequences for rahp_top.
// assumes the sva file is compiled alongside.
`timescale 1ns/1ns
module rahp_tb_top
  import rahp_pkg::*;
;
  logic clk, rst, ce, wr, rd, hit, rej;
  logic [7:0] addr, tx_clr, rx_clr, tx_go, rx_go;
  logic [31:0] wdata, rdata;
  logic [47:0] dest;
  logic [2:0] chan;
  logic [255:0] tx_ptr, rx_ptr;
  int fail_count = 0;
  int compares = 0;

  rahp_top dut (
    .I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_DEST(dest), .O_RX_HIT(hit),
    .O_RX_REJECT(rej), .O_RX_CHAN(chan), .I_TX_CLR(tx_clr), .I_RX_CLR(rx_clr),
    .O_TX_START(tx_go), .O_RX_START(rx_go), .O_TX_PTR(tx_ptr), .O_RX_PTR(rx_ptr)
  );

  // ====
  // tasks
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // data stands only in the cycle after the read edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rd_chk

  task automatic look(input logic [47:0] d, input logic [4:0] e);
    @(posedge clk);
    dest <= d;
    #1;
    chk("lookup", {27'h0, e}, {27'h0, hit, rej, chan});
  endtask : look

  // ====
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #900000;
    fail_count++;
    summarize();
  end

  // ====
  // main sequence
  initial
  begin
    rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    tx_clr = 8'h00; rx_clr = 8'h00; dest = 48'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_HIGH_OFS, HIGH_RST);
    rd_chk(TX_HDP_BASE + 8'h04, HDP_RST);
    rd_chk(INDEX_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
    // every entry is set up, and left invalid, before lookups count
    for (int n = 0; n < ENTRIES; n++)
    begin
      wr_reg(INDEX_OFS, 32'(n));
      wr_reg(ADDR_HIGH_OFS, 32'h0);
      wr_reg(ADDR_LOW_OFS, 32'h0);
    end
    for (int n = 0; n < CHANNELS; n++)
    begin
      wr_reg(TX_HDP_BASE + 8'(4 * n), 32'h0);
      wr_reg(RX_HDP_BASE + 8'(4 * n), 32'h0);
    end
    rd_chk(STATUS_OFS, 32'h0);
    wr_reg(INDEX_OFS, 32'h5);
    wr_reg(ADDR_HIGH_OFS, 32'hA1B2C3D4);
    rd_chk(ADDR_HIGH_OFS, 32'hA1B2C3D4);
    // mac = hi bytes reversed above low bytes swapped
    look(48'hD4C3B2A1F6E5, 5'h00);
    wr_reg(ADDR_LOW_OFS, 32'h001BE5F6);
    look(48'hD4C3B2A1F6E5, 5'h13);
    rd_chk(ADDR_LOW_OFS, 32'h001BE5F6);
    rd_chk(INDEX_OFS, 32'h5);
    // lookup register reflects the destination still applied
    rd_chk(LOOKUP_OFS, 32'h13);
    look(48'h54C3B2A1F6E5, 5'h00);
    // a write while the enable is low must leave the index alone
    @(posedge clk);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= INDEX_OFS;
    wdata <= 32'h1F;
    @(posedge clk);
    ce <= 1'b1;
    wr <= 1'b0;
    rd_chk(INDEX_OFS, 32'h5);
    wr_reg(INDEX_OFS, 32'h9);
    wr_reg(ADDR_LOW_OFS, 32'h0010E5F6);
    look(48'hD4C3B2A1F6E5, 5'h08);
    wr_reg(ADDR_LOW_OFS, 32'h0000E5F6);
    look(48'hD4C3B2A1F6E5, 5'h13);
    for (int n = 0; n < CHANNELS; n++)
    begin
      wr_reg(TX_HDP_BASE + 8'(4 * n), 32'h100 + n);
      chk("tx start", 32'(1 << n), {24'h0, tx_go});
      chk("tx ptr", 32'h100 + n, tx_ptr[32 * n +: 32]);
      wr_reg(RX_HDP_BASE + 8'(4 * n), 32'h200 + n);
      chk("rx start", 32'(1 << n), {24'h0, rx_go});
      chk("rx ptr", 32'h200 + n, rx_ptr[32 * n +: 32]);
    end
    rd_chk(STATUS_OFS, 32'h0);
    wr_reg(TX_HDP_BASE, 32'h300);
    rd_chk(STATUS_OFS, 32'h1);
    wr_reg(RX_HDP_BASE, 32'h0);
    chk("rx start", 32'h0, {24'h0, rx_go});
    rd_chk(STATUS_OFS, 32'h101);
    wr_reg(STATUS_OFS, 32'h0000FFFF);
    rd_chk(STATUS_OFS, 32'h0);
    // dma retires channel one, so a fresh write is legal
    @(posedge clk);
    tx_clr <= 8'h02;
    @(posedge clk);
    tx_clr <= 8'h00;
    #1;
    chk("tx ptr", 32'h0, tx_ptr[63:32]);
    wr_reg(TX_HDP_BASE + 8'h04, 32'h5);
    rd_chk(STATUS_OFS, 32'h0);
    // a second reset mid-run clears pointers, index and entries
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("tx ptr", 32'h0, tx_ptr[63:32]);
    chk("rx ptr", 32'h0, rx_ptr[255:224]);
    rd_chk(INDEX_OFS, 32'h0);
    rd_chk(ADDR_HIGH_OFS, HIGH_RST);
    look(48'hD4C3B2A1F6E5, 5'h00);
    summarize();
  end
endmodule : rahp_tb_top
